// ==== logic/wei_pkg.sv ====
// Constants, register map and field layout for the wake event indicator
package wei_pkg;
  // Register byte addresses
  localparam logic [11:0] WEI_PMC_ADDR      = 12'h084; // power_mgmt_control
  localparam logic [11:0] WEI_BYTE_TEST_ADR = 12'h064; // Wake-up write target
  localparam logic [11:0] WEI_ADDR_MASK     = 12'hffc; // Word alignment
  // Field positions inside power_mgmt_control
  localparam int WEI_MODE_LO   = 12;
  localparam int WEI_MODE_HI   = 13;
  localparam int WEI_WFE_BIT   = 9;  // wake_frame_enable
  localparam int WEI_EDE_BIT   = 8;  // energy_detect_enable
  localparam int WEI_DRV_BIT   = 6;  // wake_out_driver_type
  localparam int WEI_CAUSE_LO  = 4;  // wake_cause_field low bit
  localparam int WEI_CAUSE_HI  = 5;
  localparam int WEI_PSEL_BIT  = 3;  // wake_pulse_select
  localparam int WEI_POL_BIT   = 2;  // wake_out_polarity
  localparam int WEI_OEN_BIT   = 1;  // wake_out_enable
  localparam int WEI_RDY_BIT   = 0;  // Device ready flag
  // Power state encodings
  typedef enum logic [1:0] {
    WEI_FULL_POWER   = 2'b00, // full_power_state
    WEI_WFRAME_SLEEP = 2'b01, // wake_frame_sleep_state
    WEI_ENERGY_SLEEP = 2'b10, // energy_detect_sleep_state
    WEI_MODE_RSVD    = 2'b11
  } wei_mode_e;
  // Wake cause codes
  localparam logic [1:0] WEI_CAUSE_NONE   = 2'b00;
  localparam logic [1:0] WEI_CAUSE_ENERGY = 2'b01;
  localparam logic [1:0] WEI_CAUSE_FRAME  = 2'b10;
  localparam logic [1:0] WEI_CAUSE_MULTI  = 2'b11;
  // AXI responses
  localparam logic [1:0] WEI_RESP_OKAY   = 2'b00;
  localparam logic [1:0] WEI_RESP_SLVERR = 2'b10;
  // Timing
  localparam int WEI_CLK_HZ      = 25_000_000;
  localparam int WEI_PULSE_MS    = 50;
  localparam int WEI_PULSE_CYC   = (WEI_CLK_HZ / 1000) * WEI_PULSE_MS;
  localparam int WEI_READY_CYC   = 64; // Settling time before ready
  localparam int WEI_CNT_W       = 21;
  localparam logic [31:0] WEI_BYTE_TEST_VAL = 32'h0000_0000; // Arbitrary read value
endpackage

// ==== logic/wei_top.sv ====
// Wake event indicator: power_mgmt_control register, wake output and ready flag
`timescale 1ns/1ps

module wei_top #(
  parameter int PULSE_CYCLES = wei_pkg::WEI_PULSE_CYC,
  parameter int READY_CYCLES = wei_pkg::WEI_READY_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        energy_pending,      // Energy detector source, level, async
  input  wire logic        frame_pending,       // Wake frame / magic packet source, level, async
  output logic             wake_event_output,   // Pin level
  output logic             wake_event_output_oe,// High while pin driven
  output logic             wake_event_interrupt,
  output logic [1:0]       power_state_select,
  output logic             device_ready
);
  import wei_pkg::*;

  // Bus capture
  logic [11:0] aw_addr_r;
  logic        aw_held_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_held_r;
  logic        wr_commit;    // Both halves of a write held
  logic        wr_pmc;       // Commit aimed at the control register
  logic        wr_btest;     // Commit aimed at byte test
  // Control fields
  wei_mode_e   mode_r;
  logic        wfe_r, ede_r, drv_r, psel_r, pol_r, oen_r;
  logic [1:0]  cause_r;
  logic [1:0]  cause_nxt;
  logic        ready_r;
  logic [WEI_CNT_W-1:0] rdy_cnt_r;
  // Event path
  logic [1:0]  sync1_r, sync2_r, sync3_r; // {frame, energy}
  logic [1:0]  evt_hit;      // Enabled rising edges
  logic        active_r;     // Logical wake output state
  logic        deact;
  logic [WEI_CNT_W-1:0] pulse_cnt_r;
  logic        can_clear;

  // Address match with word alignment
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] t);
    return (a & WEI_ADDR_MASK) == t;
  endfunction

  // Read image of the control register, reserved bits zero
  function automatic logic [31:0] pmc_image();
    logic [31:0] v;
    v = 32'h0000_0000;
    v[WEI_MODE_HI:WEI_MODE_LO]   = mode_r;
    v[WEI_WFE_BIT]               = wfe_r;
    v[WEI_EDE_BIT]               = ede_r;
    v[WEI_DRV_BIT]               = drv_r;
    v[WEI_CAUSE_HI:WEI_CAUSE_LO] = cause_r;
    v[WEI_PSEL_BIT]              = psel_r;
    v[WEI_POL_BIT]               = pol_r;
    v[WEI_OEN_BIT]               = oen_r;
    v[WEI_RDY_BIT]               = ready_r;
    return v;
  endfunction

  assign wr_commit = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_pmc    = wr_commit && addr_is(aw_addr_r, WEI_PMC_ADDR);
  assign wr_btest  = wr_commit && addr_is(aw_addr_r, WEI_BYTE_TEST_ADR);

  // Write address channel; ready returns only after the response drains
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_held_r     <= 1'b1;
      aw_addr_r     <= s_axi_awaddr;
    end else if (wr_commit) begin
      aw_held_r     <= 1'b0;
    end else if (!aw_held_r && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b0;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_held_r     <= 1'b1;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
    end else if (wr_commit) begin
      w_held_r     <= 1'b0;
    end else if (!w_held_r && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= WEI_RESP_OKAY;
    end else if (wr_commit) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_pmc || wr_btest) ? WEI_RESP_OKAY : WEI_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel; control register answers in every power state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= WEI_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      if (addr_is(s_axi_araddr, WEI_PMC_ADDR)) begin
        s_axi_rdata <= pmc_image();
        s_axi_rresp <= WEI_RESP_OKAY;
      end else if (addr_is(s_axi_araddr, WEI_BYTE_TEST_ADR)) begin
        s_axi_rdata <= WEI_BYTE_TEST_VAL;
        s_axi_rresp <= WEI_RESP_OKAY;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= WEI_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // Plain read/write control bits in the low byte and enables in byte one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wfe_r  <= 1'b0;
      ede_r  <= 1'b0;
      drv_r  <= 1'b0;
      psel_r <= 1'b0;
      pol_r  <= 1'b0;
      oen_r  <= 1'b0;
    end else if (wr_pmc) begin
      if (w_strb_r[0]) begin
        drv_r  <= w_data_r[WEI_DRV_BIT];
        psel_r <= w_data_r[WEI_PSEL_BIT];
        pol_r  <= w_data_r[WEI_POL_BIT];
        oen_r  <= w_data_r[WEI_OEN_BIT];
      end
      if (w_strb_r[1]) begin
        wfe_r  <= w_data_r[WEI_WFE_BIT];
        ede_r  <= w_data_r[WEI_EDE_BIT];
      end
    end
  end

  // Power state; reserved code is refused, byte test write returns to full power
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= WEI_FULL_POWER;
    end else if (wr_btest && mode_r != WEI_FULL_POWER) begin
      mode_r <= WEI_FULL_POWER;
    end else if (wr_pmc && w_strb_r[1]) begin
      case (wei_mode_e'(w_data_r[WEI_MODE_HI:WEI_MODE_LO]))
        WEI_FULL_POWER:   mode_r <= WEI_FULL_POWER;
        WEI_WFRAME_SLEEP: mode_r <= WEI_WFRAME_SLEEP;
        WEI_ENERGY_SLEEP: mode_r <= WEI_ENERGY_SLEEP;
        default:          mode_r <= mode_r;
      endcase
    end
  end

  // Ready counts settling cycles in full power; any sleep drops it at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ready_r   <= 1'b0;
      rdy_cnt_r <= '0;
    end else if (mode_r != WEI_FULL_POWER) begin
      ready_r   <= 1'b0;
      rdy_cnt_r <= '0;
    end else if (!ready_r) begin
      if (rdy_cnt_r == WEI_CNT_W'(READY_CYCLES - 1)) begin
        ready_r <= 1'b1;
      end
      rdy_cnt_r <= rdy_cnt_r + 1'b1;
    end
  end

  // Two-flop synchronisers, third stage for edge detection only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 2'b00;
      sync2_r <= 2'b00;
      sync3_r <= 2'b00;
    end else begin
      sync1_r <= {frame_pending, energy_pending};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // Enabled source edges; each source owns one cause bit
  assign evt_hit[0] = sync2_r[0] && !sync3_r[0] && ede_r;
  assign evt_hit[1] = sync2_r[1] && !sync3_r[1] && wfe_r;
  assign can_clear  = ready_r && (mode_r == WEI_FULL_POWER);

  // Cause field next value: set beats clear
  always_comb begin
    cause_nxt = cause_r;
    if (wr_pmc && w_strb_r[0] && can_clear) begin
      cause_nxt = cause_r & ~(w_data_r[WEI_CAUSE_HI:WEI_CAUSE_LO] & ~sync2_r);
    end
    cause_nxt = cause_nxt | evt_hit;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_r <= WEI_CAUSE_NONE;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // Output drops once no recorded cause has its enable left
  assign deact = !((cause_nxt[0] && ede_r) || (cause_nxt[1] && wfe_r));

  // Logical wake output with pulse timer; a new event never restarts a pulse
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r    <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (deact) begin
      active_r    <= 1'b0;
      pulse_cnt_r <= '0;
    end else if (active_r) begin
      if (psel_r) begin
        if (pulse_cnt_r == WEI_CNT_W'(PULSE_CYCLES - 1)) begin
          active_r <= 1'b0;
        end
        pulse_cnt_r <= pulse_cnt_r + 1'b1;
      end
    end else if (|evt_hit) begin
      active_r    <= 1'b1;
      pulse_cnt_r <= '0;
    end
  end

  // Pin drive: push-pull honours polarity, open-drain only pulls low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_event_output    <= 1'b0;
      wake_event_output_oe <= 1'b0;
    end else if (drv_r) begin
      wake_event_output_oe <= 1'b1;
      wake_event_output    <= pol_r ? (active_r && oen_r) : !(active_r && oen_r);
    end else begin
      wake_event_output_oe <= active_r && oen_r;
      wake_event_output    <= 1'b0;
    end
  end

  // Interrupt follows the cause field and ignores the output enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_event_interrupt <= 1'b0;
      power_state_select   <= WEI_FULL_POWER;
      device_ready         <= 1'b0;
    end else begin
      wake_event_interrupt <= |cause_r;
      power_state_select   <= mode_r;
      device_ready         <= ready_r;
    end
  end

  a_cause_early_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (cause_r[0] && !can_clear) |=> cause_r[0]) else $error("cause cleared before ready");
  a_cause_pend_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (cause_r[1] && sync2_r[1]) |=> cause_r[1]) else $error("cause cleared while pending");
  a_cause_w1c: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_pmc && w_strb_r[0] && can_clear && w_data_r[WEI_CAUSE_LO] && !sync2_r[0] && !evt_hit[0])
    |=> !cause_r[0]) else $error("write one did not clear cause");
  a_pulse_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    (active_r && psel_r) |-> (pulse_cnt_r < WEI_CNT_W'(PULSE_CYCLES))) else $error("pulse overran");
  a_pulse_end: assert property (@(posedge aclk) disable iff (!aresetn)
    (active_r && psel_r && pulse_cnt_r == WEI_CNT_W'(PULSE_CYCLES - 1)) |=> !active_r)
    else $error("pulse did not end");
  a_static_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (active_r && !psel_r && !deact) |=> active_r) else $error("static output dropped");
  a_od_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (!$past(drv_r) && wake_event_output_oe) |-> !wake_event_output) else $error("open drain drove high");
  a_out_gate: assert property (@(posedge aclk) disable iff (!aresetn)
    (!oen_r && !drv_r) |=> !wake_event_output_oe) else $error("output asserted while disabled");
  a_int_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (|cause_r) |=> wake_event_interrupt) else $error("interrupt missed cause");
  a_sleep_unready: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_r != WEI_FULL_POWER) |=> ##1 !device_ready) else $error("ready high in sleep");
endmodule

// ==== dv/wei_wake_model.sv ====
// Far-side model: wake event sources and the system wake line
`timescale 1ns/1ps
module wei_wake_model (
  input  wire logic en_req,               // Bench asks for an energy event
  input  wire logic fr_req,               // Bench asks for a frame event
  output logic      energy_pending,       // Energy source level
  output logic      frame_pending,        // Frame source level
  input  wire logic wake_event_output,    // Device pin value
  input  wire logic wake_event_output_oe, // Device drives the pin
  output logic      pin_level             // Resolved wire level
);
  // Sources are plain levels, held until the bench drops them
  assign energy_pending = en_req;
  assign frame_pending  = fr_req;
  // Wired-OR line with a pull-up, so a released pin reads high, never stale
  assign pin_level = wake_event_output_oe ? wake_event_output : 1'b1;
endmodule

// ==== dv/tb.sv ====
// Self-checking testbench for the wake event indicator
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import wei_pkg::*;
  localparam int PC = 20;                        // Short pulse keeps the run brief
  logic        aclk = 0, aresetn = 0;             // Clock and reset
  logic [11:0] awaddr = 0, araddr = 0;            // Bus addresses
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, d;               // Write, read and captured data
  logic [3:0]  wstrb = 4'hf;                      // All lanes written
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, pss, r;              // Responses and power state
  logic        en_req = 0, fr_req = 0;            // Source requests
  logic        ep, fp, wout, woe, wint, rdy, pin; // Far-side wires
  int          n_errors = 0, compares = 0, n;     // Score counters
  always #20 aclk = ~aclk;
  wei_top #(.PULSE_CYCLES(PC), .READY_CYCLES(4)) wei_top_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .energy_pending(ep),
    .frame_pending(fp), .wake_event_output(wout), .wake_event_output_oe(woe),
    .wake_event_interrupt(wint), .power_state_select(pss), .device_ready(rdy));
  wei_wake_model wei_wake_model_inst (.en_req(en_req), .fr_req(fr_req),
    .energy_pending(ep), .frame_pending(fp), .wake_event_output(wout),
    .wake_event_output_oe(woe), .pin_level(pin));
  // Control word: mode, enables, driver, clear bits, pulse, polarity, output enable
  function automatic logic [31:0] pmc(logic [1:0] m, logic wfe, ede, drv, logic [1:0] clr,
                                      logic psel, pol, oen);
    pmc = {18'h0, m, 2'h0, wfe, ede, 1'b0, drv, clr, psel, pol, oen, 1'b0};
  endfunction
  // Settle after n edges, sampling away from the clock edge
  task automatic cyc(input int c);
    repeat (c) @(negedge aclk);
  endtask
  // Source levels change just after a rising edge
  task automatic src(input logic e, f);
    @(posedge aclk);
    en_req <= e;
    fr_req <= f;
  endtask
  // Write: address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
    logic ha, hw, da, dw, hb;
    da = 0;
    dw = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(da && dw)) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      @(posedge aclk);
      if (ha) begin
        awvalid <= 0;
        da = 1;
      end
      if (hw) begin
        wvalid <= 0;
        dw = 1;
      end
    end
    // Hold bready until the response is seen at an edge
    do begin
      @(negedge aclk);
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
    end while (!hb);
    bready <= 0;
    `CHK(r, er)
  endtask
  // Read: address held until taken, data captured at the answering edge
  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rr);
    logic h;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 0;
    do begin
      @(negedge aclk);
      h = rvalid;
      v = rdata;
      rr = rresp;
      @(posedge aclk);
    end while (!h);
    rready <= 0;
  endtask
  // Ready after reset, fresh field values, unmapped access
  task automatic t_ready;
    @(negedge aclk);
    `CHK(rdy, 1'b0)
    while (rdy !== 1'b1) @(negedge aclk);
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[0], 1'b1)
    `CHK(d[5:4], WEI_CAUSE_NONE)
    `CHK(pss, WEI_FULL_POWER)
    rd(12'h010, d, r);
    `CHK({r, d}, {WEI_RESP_SLVERR, 32'h0})
    wr(12'h010, 32'hffff_ffff, WEI_RESP_SLVERR);
    $display("test ready done");
  endtask
  // Static output, clear blocked while pending, per-bit clearing
  task automatic t_static;
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 1, 0, 0, 1, 1), WEI_RESP_OKAY);
    cyc(2);
    `CHK(pin, 1'b0)
    src(1, 0);
    cyc(8);
    `CHK(wint, 1'b1)
    `CHK(pin, 1'b1)
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 1, 2'b01, 0, 1, 1), WEI_RESP_OKAY);
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[5:4], WEI_CAUSE_ENERGY)
    src(0, 0);
    cyc(30);
    `CHK(pin, 1'b1)
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 1, 2'b10, 0, 1, 1), WEI_RESP_OKAY);
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[5:4], WEI_CAUSE_ENERGY)
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 1, 2'b01, 0, 1, 1), WEI_RESP_OKAY);
    cyc(4);
    `CHK({pin, wint}, 2'b00)
    $display("test static done");
  endtask
  // Two different sources give the multiple-event code
  task automatic t_multi;
    wr(WEI_PMC_ADDR, pmc(0, 1, 1, 1, 0, 0, 1, 1), WEI_RESP_OKAY);
    src(1, 0);
    cyc(8);
    src(0, 1);
    cyc(8);
    src(0, 0);
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[5:4], WEI_CAUSE_MULTI)
    wr(WEI_PMC_ADDR, pmc(0, 1, 1, 1, 2'b11, 0, 1, 1), WEI_RESP_OKAY);
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[5:4], WEI_CAUSE_NONE)
    $display("test multi done");
  endtask
  // Pulse mode, active low; a second edge inside the pulse must not stretch it
  task automatic t_pulse;
    wr(WEI_PMC_ADDR, pmc(0, 1, 0, 1, 0, 1, 0, 1), WEI_RESP_OKAY);
    src(0, 1);
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge aclk);
      if (i == 5) fr_req <= 0;
      if (i == 10) fr_req <= 1;
      @(negedge aclk);
      if (pin === 1'b0) n++;
    end
    `CHK(n, PC)
    `CHK(wint, 1'b1)
    src(0, 0);
    wr(WEI_PMC_ADDR, pmc(0, 1, 0, 1, 2'b11, 1, 0, 1), WEI_RESP_OKAY);
    $display("test pulse done");
  endtask
  // Open drain: enable gates the pin only, polarity ignored, enable clear deactivates
  task automatic t_od;
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 0, 0, 0, 1, 0), WEI_RESP_OKAY);
    src(1, 0);
    cyc(8);
    `CHK({wint, woe, pin}, 3'b101)
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 0, 0, 0, 1, 1), WEI_RESP_OKAY);
    cyc(4);
    `CHK({wint, woe, pin}, 3'b110)
    src(0, 0);
    wr(WEI_PMC_ADDR, pmc(0, 0, 0, 0, 0, 0, 1, 1), WEI_RESP_OKAY);
    cyc(4);
    `CHK({wint, pin}, 2'b11)
    wr(WEI_PMC_ADDR, pmc(0, 0, 0, 0, 2'b01, 0, 1, 1), WEI_RESP_OKAY);
    $display("test open drain done");
  endtask
  // Both sleep states, clear refused while asleep, wake by byte test write
  task automatic t_sleep;
    wr(WEI_PMC_ADDR, pmc(0, 0, 1, 1, 0, 0, 1, 1), WEI_RESP_OKAY);
    src(1, 0);
    cyc(8);
    src(0, 0);
    for (int m = 1; m < 3; m++) begin
      wr(WEI_PMC_ADDR, pmc(m[1:0], 0, 1, 1, 0, 0, 1, 1), WEI_RESP_OKAY);
      cyc(2);
      `CHK({pss, rdy}, {m[1:0], 1'b0})
      wr(WEI_PMC_ADDR, pmc(m[1:0], 0, 1, 1, 2'b01, 0, 1, 1), WEI_RESP_OKAY);
      rd(WEI_PMC_ADDR, d, r);
      `CHK({r, d[0]}, {WEI_RESP_OKAY, 1'b0})
      `CHK(d[5:4], WEI_CAUSE_ENERGY)
      wr(WEI_BYTE_TEST_ADR, 32'h0, WEI_RESP_OKAY);
      while (rdy !== 1'b1) @(negedge aclk);
      `CHK(pss, WEI_FULL_POWER)
    end
    wr(WEI_PMC_ADDR, pmc(2'b11, 0, 1, 1, 2'b01, 0, 1, 1), WEI_RESP_OKAY);
    cyc(2);
    `CHK(pss, WEI_FULL_POWER)
    rd(WEI_PMC_ADDR, d, r);
    `CHK(d[5:4], WEI_CAUSE_NONE)
    // Low lane only: the mode field in lane one must stay put
    @(posedge aclk);
    wstrb <= 4'h1;
    wr(WEI_PMC_ADDR, pmc(1, 0, 1, 1, 0, 0, 1, 1), WEI_RESP_OKAY);
    wstrb <= 4'hf;
    cyc(2);
    `CHK({pss, rdy}, {WEI_FULL_POWER, 1'b1})
    $display("test sleep done");
  endtask
  // Single place where the run ends
  task automatic end_sim;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog: the tests need well under ten thousand cycles
  initial begin
    #400_000;
    n_errors++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_ready();
    t_static();
    t_multi();
    t_pulse();
    t_od();
    t_sleep();
    end_sim();
  end
endmodule
